//--- rtl/psmd_params.svh
`ifndef PSMD_PARAMS_SVH
`define PSMD_PARAMS_SVH

// Bank one switch positions (1 = right/up)
`define PSMD_B1_NEG1_BIT     0
`define PSMD_B1_NEG2_BIT     1
`define PSMD_B1_LM0_BIT      5
`define PSMD_B1_LM1_BIT      6
`define PSMD_B1_LM2_BIT      7
// Bank two switch positions
`define PSMD_B2_LANE_A_BIT   0
`define PSMD_B2_LANE_B_BIT   1
`define PSMD_B2_PAUSE_BIT    2
`define PSMD_B2_SUBORD_BIT   3
// Bank width and reset (factory default) value
`define PSMD_BANK_W          8
`define PSMD_BANK_RST        8'h00
// Link-mode codes, bit0 = first link-mode switch
`define PSMD_LM_SEG          3'h0
`define PSMD_LM_PROP         3'h1
`define PSMD_LM_RFD_SEG      3'h2
`define PSMD_LM_RFD_PROP     3'h3
`define PSMD_LM_SFD          3'h4

`endif

//--- rtl/psmd_pkg.sv
package psmd_pkg;

   // One-hot decoded link mode
   typedef enum logic [4:0] {
      PSMD_LINK_SEGMENT   = 5'h01,
      PSMD_LINK_PROPAGATE = 5'h02,
      PSMD_RFD_SEGMENT    = 5'h04,
      PSMD_RFD_PROPAGATE  = 5'h08,
      PSMD_SYM_FAULT      = 5'h10
   } psmd_link_mode_t;

   // Pause flow-control arbitration state for fiber port two
   typedef enum logic [2:0] {
      PSMD_PS_IDLE   = 3'h1,
      PSMD_PS_HOLD   = 3'h2,
      PSMD_PS_SENT   = 3'h4
   } psmd_pause_state_t;

endpackage : psmd_pkg

//--- rtl/psmd_sync2.sv
`timescale 1ns/1ps
`include "psmd_params.svh"

// Two-stage synchroniser for a bank of static switches
module psmd_sync2 #(
   parameter int WIDTH = 8
) (
   input  wire logic             CLOCK_IN,
   input  wire logic             RESET_N_IN,
   input  wire logic [WIDTH-1:0] ASYNC_IN,
   output logic      [WIDTH-1:0] SYNC_OUT
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   initial begin
      if (WIDTH < 1) $error("psmd_sync2: WIDTH must be positive");
   end

   always_comb begin
      meta_d = ASYNC_IN;
      sync_d = meta_q;
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign SYNC_OUT = sync_q;
endmodule : psmd_sync2

//--- rtl/psmd_link_decode.sv
`timescale 1ns/1ps
`include "psmd_params.svh"

// Three-switch link-mode code to one-hot mode
module psmd_link_decode
   import psmd_pkg::*;
(
   input  wire logic [2:0]      CODE_IN,
   output psmd_link_mode_t      MODE_OUT
);
   always_comb begin
      case (CODE_IN)
         `PSMD_LM_SEG:      MODE_OUT = PSMD_LINK_SEGMENT;
         `PSMD_LM_PROP:     MODE_OUT = PSMD_LINK_PROPAGATE;
         `PSMD_LM_RFD_SEG:  MODE_OUT = PSMD_RFD_SEGMENT;
         `PSMD_LM_RFD_PROP: MODE_OUT = PSMD_RFD_PROPAGATE;
         `PSMD_LM_SFD:      MODE_OUT = PSMD_SYM_FAULT;
         // Illegal combinations fall back to the safe mode
         default:           MODE_OUT = PSMD_LINK_SEGMENT;
      endcase
   end
endmodule : psmd_link_decode

//--- rtl/psmd_top.sv
`timescale 1ns/1ps
`include "psmd_params.svh"

module psmd_top
   import psmd_pkg::*;
(
   input  wire logic                   CLOCK_IN,
   input  wire logic                   RESET_N_IN,
   input  wire logic [`PSMD_BANK_W-1:0] BANK1_SW_IN,
   input  wire logic [`PSMD_BANK_W-1:0] BANK2_SW_IN,
   input  wire logic                   PORT2_PAUSE_RX_IN,
   input  wire logic                   BUFFER_CONGESTED_IN,
   input  wire logic                   PAUSE_SENT_IN,
   input  wire logic                   MASTER_ELECTED_IN,
   output logic                        PORT1_AUTO_NEGOTIATE_OUT,
   output logic                        PORT2_AUTO_NEGOTIATE_OUT,
   output logic                        PORT1_PAUSE_ADVERTISE_OUT,
   output logic                        PORT2_PAUSE_ADVERTISE_OUT,
   output logic                        PORT1_FULL_DUPLEX_OUT,
   output logic                        PORT2_FULL_DUPLEX_OUT,
   output logic                        LINK_SEGMENT_MODE_OUT,
   output logic                        LINK_PROPAGATE_MODE_OUT,
   output logic                        REMOTE_FAULT_DETECT_MODE_OUT,
   output logic                        SYMMETRIC_FAULT_DETECT_MODE_OUT,
   output logic                        BACKPLANE_LANE_A_OFF_OUT,
   output logic                        BACKPLANE_LANE_B_OFF_OUT,
   output logic                        PORT2_PAUSE_ENABLE_OUT,
   output logic                        PORT2_TX_HOLD_OUT,
   output logic                        PORT2_PAUSE_TX_REQ_OUT,
   output logic                        MASTERSHIP_AUTO_SELECT_OUT,
   output logic                        SUBORDINATE_ONLY_MODE_OUT,
   output logic                        MASTER_CLAIM_OUT
);

   // =====================================================
   // Switch, received-pause and congestion synchronisers
   // =====================================================
   logic [`PSMD_BANK_W-1:0] bank1_s;
   logic [`PSMD_BANK_W-1:0] bank2_s;
   logic                    rx_pause_s;
   logic                    congested_s;

   psmd_sync2 #(.WIDTH(`PSMD_BANK_W + `PSMD_BANK_W + 2)) u_sync (
      .CLOCK_IN   (CLOCK_IN),
      .RESET_N_IN (RESET_N_IN),
      .ASYNC_IN   ({BUFFER_CONGESTED_IN, PORT2_PAUSE_RX_IN, BANK2_SW_IN, BANK1_SW_IN}),
      .SYNC_OUT   ({congested_s, rx_pause_s, bank2_s, bank1_s})
   );

   // =====================================================
   // Link-mode decode
   // =====================================================
   logic [2:0]      lm_code_w;
   psmd_link_mode_t mode_w;

   assign lm_code_w = {bank1_s[`PSMD_B1_LM2_BIT], bank1_s[`PSMD_B1_LM1_BIT],
                       bank1_s[`PSMD_B1_LM0_BIT]};

   psmd_link_decode u_dec (
      .CODE_IN  (lm_code_w),
      .MODE_OUT (mode_w)
   );

   // =====================================================
   // Decoded settings, held between switch changes
   // =====================================================
   logic            an1_q;
   logic            an1_d;
   logic            an2_q;
   logic            an2_d;
   psmd_link_mode_t mode_q;
   psmd_link_mode_t mode_d;
   logic            lane_a_off_q;
   logic            lane_a_off_d;
   logic            lane_b_off_q;
   logic            lane_b_off_d;
   logic            pause_en_q;
   logic            pause_en_d;
   logic            subord_q;
   logic            subord_d;

   always_comb begin
      an1_d        = ~bank1_s[`PSMD_B1_NEG1_BIT];
      an2_d        = ~bank1_s[`PSMD_B1_NEG2_BIT];
      mode_d       = mode_w;
      lane_a_off_d = ~bank2_s[`PSMD_B2_LANE_A_BIT];
      lane_b_off_d = ~bank2_s[`PSMD_B2_LANE_B_BIT];
      pause_en_d   = bank2_s[`PSMD_B2_PAUSE_BIT];
      subord_d     = bank2_s[`PSMD_B2_SUBORD_BIT];
   end

   // Reset values equal the factory-default switch positions
   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         an1_q        <= 1'b1;
         an2_q        <= 1'b1;
         mode_q       <= PSMD_LINK_SEGMENT;
         lane_a_off_q <= 1'b1;
         lane_b_off_q <= 1'b1;
         pause_en_q   <= 1'b0;
         subord_q     <= 1'b0;
      end else begin
         an1_q        <= an1_d;
         an2_q        <= an2_d;
         mode_q       <= mode_d;
         lane_a_off_q <= lane_a_off_d;
         lane_b_off_q <= lane_b_off_d;
         pause_en_q   <= pause_en_d;
         subord_q     <= subord_d;
      end
   end

   // =====================================================
   // Port two pause flow control
   // =====================================================
   psmd_pause_state_t ps_q;
   psmd_pause_state_t ps_d;
   logic              hold_q;
   logic              hold_d;
   logic              ptx_q;
   logic              ptx_d;

   always_comb begin
      ps_d   = ps_q;
      hold_d = 1'b0;
      ptx_d  = 1'b0;
      case (ps_q)
         PSMD_PS_IDLE: begin
            if (pause_en_q && congested_s) begin
               ps_d  = PSMD_PS_HOLD;
               ptx_d = 1'b1;
            end
         end
         PSMD_PS_HOLD: begin
            // Request stands until the MAC reports the frame sent
            ptx_d = ~PAUSE_SENT_IN;
            if (PAUSE_SENT_IN) begin
               ps_d = PSMD_PS_SENT;
            end
         end
         PSMD_PS_SENT: begin
            // One pause per congestion episode; re-arm on clear
            if (!congested_s || !pause_en_q) begin
               ps_d = PSMD_PS_IDLE;
            end
         end
         default: ps_d = PSMD_PS_IDLE;
      endcase
      if (!pause_en_q) begin
         ps_d  = PSMD_PS_IDLE;
         ptx_d = 1'b0;
      end
      // Received pause stops our transmit; frames queue in the buffer
      hold_d = pause_en_q & rx_pause_s;
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         ps_q   <= PSMD_PS_IDLE;
         hold_q <= 1'b0;
         ptx_q  <= 1'b0;
      end else begin
         ps_q   <= ps_d;
         hold_q <= hold_d;
         ptx_q  <= ptx_d;
      end
   end

   // =====================================================
   // Mastership
   // =====================================================
   logic claim_q;
   logic claim_d;

   always_comb begin
      // Subordinate-only never claims, even if elected
      claim_d = ~subord_q & MASTER_ELECTED_IN;
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         claim_q <= 1'b0;
      end else begin
         claim_q <= claim_d;
      end
   end

   // =====================================================
   // Outputs
   // =====================================================
   assign PORT1_AUTO_NEGOTIATE_OUT        = an1_q;
   assign PORT2_AUTO_NEGOTIATE_OUT        = an2_q;
   assign PORT1_PAUSE_ADVERTISE_OUT       = an1_q;
   assign PORT2_PAUSE_ADVERTISE_OUT       = an2_q & pause_en_q;
   assign PORT1_FULL_DUPLEX_OUT           = 1'b1;
   assign PORT2_FULL_DUPLEX_OUT           = 1'b1;
   assign LINK_SEGMENT_MODE_OUT           = mode_q[0] | mode_q[2];
   assign LINK_PROPAGATE_MODE_OUT         = mode_q[1] | mode_q[3];
   assign REMOTE_FAULT_DETECT_MODE_OUT    = mode_q[2] | mode_q[3];
   assign SYMMETRIC_FAULT_DETECT_MODE_OUT = mode_q[4];
   assign BACKPLANE_LANE_A_OFF_OUT        = lane_a_off_q;
   assign BACKPLANE_LANE_B_OFF_OUT        = lane_b_off_q;
   assign PORT2_PAUSE_ENABLE_OUT          = pause_en_q;
   assign PORT2_TX_HOLD_OUT               = hold_q;
   assign PORT2_PAUSE_TX_REQ_OUT          = ptx_q;
   assign MASTERSHIP_AUTO_SELECT_OUT      = ~subord_q;
   assign SUBORDINATE_ONLY_MODE_OUT       = subord_q;
   assign MASTER_CLAIM_OUT                = claim_q;

   // =====================================================
   // Checks
   // =====================================================
   chk_negotiation_port_one: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      ##3 (PORT1_AUTO_NEGOTIATE_OUT == !$past(BANK1_SW_IN[`PSMD_B1_NEG1_BIT], 3)))
      else $error("port one negotiation mismatch");

   chk_negotiation_port_two: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      ##3 (PORT2_AUTO_NEGOTIATE_OUT == !$past(BANK1_SW_IN[`PSMD_B1_NEG2_BIT], 3)))
      else $error("port two negotiation mismatch");

   chk_pause_advertise_manual: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      !PORT1_AUTO_NEGOTIATE_OUT |-> !PORT1_PAUSE_ADVERTISE_OUT)
      else $error("manual port advertises pause");

   chk_full_duplex_always: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      PORT1_FULL_DUPLEX_OUT && PORT2_FULL_DUPLEX_OUT)
      else $error("fiber port not full duplex");

   chk_illegal_code_segment: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (bank1_s[`PSMD_B1_LM2_BIT] && (bank1_s[`PSMD_B1_LM0_BIT] || bank1_s[`PSMD_B1_LM1_BIT]))
      |=> (LINK_SEGMENT_MODE_OUT && !REMOTE_FAULT_DETECT_MODE_OUT))
      else $error("illegal link code not segment");

   chk_sym_fault_decode: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (lm_code_w == `PSMD_LM_SFD) |=> SYMMETRIC_FAULT_DETECT_MODE_OUT)
      else $error("symmetrical fault mode missed");

   chk_pause_off_quiet: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      !$past(pause_en_q) |-> (!PORT2_PAUSE_TX_REQ_OUT && !PORT2_TX_HOLD_OUT))
      else $error("pause activity while disabled");

   chk_congestion_pause_tx: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (ps_q == PSMD_PS_IDLE && pause_en_q && congested_s) |=> PORT2_PAUSE_TX_REQ_OUT)
      else $error("congestion without pause request");

   chk_subordinate_no_claim: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      $past(subord_q) |-> !MASTER_CLAIM_OUT)
      else $error("subordinate claimed mastership");

   chk_segment_code_decode: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (lm_code_w == `PSMD_LM_SEG) |=> (LINK_SEGMENT_MODE_OUT && !LINK_PROPAGATE_MODE_OUT &&
         !REMOTE_FAULT_DETECT_MODE_OUT && !SYMMETRIC_FAULT_DETECT_MODE_OUT))
      else $error("segment code not decoded");

   chk_propagate_code_decode: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (lm_code_w == `PSMD_LM_PROP) |=> (LINK_PROPAGATE_MODE_OUT && !LINK_SEGMENT_MODE_OUT &&
         !REMOTE_FAULT_DETECT_MODE_OUT && !SYMMETRIC_FAULT_DETECT_MODE_OUT))
      else $error("propagate code not decoded");

   chk_rfd_segment_decode: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (lm_code_w == `PSMD_LM_RFD_SEG) |=> (REMOTE_FAULT_DETECT_MODE_OUT &&
         LINK_SEGMENT_MODE_OUT && !LINK_PROPAGATE_MODE_OUT))
      else $error("fault detect with segment not decoded");

   chk_rfd_propagate_decode: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (lm_code_w == `PSMD_LM_RFD_PROP) |=> (REMOTE_FAULT_DETECT_MODE_OUT &&
         LINK_PROPAGATE_MODE_OUT && !LINK_SEGMENT_MODE_OUT))
      else $error("fault detect with propagate not decoded");

   chk_lane_a_isolation: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      ##1 (BACKPLANE_LANE_A_OFF_OUT == !$past(bank2_s[`PSMD_B2_LANE_A_BIT])))
      else $error("backplane lane a state wrong");

   chk_lane_b_isolation: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      ##1 (BACKPLANE_LANE_B_OFF_OUT == !$past(bank2_s[`PSMD_B2_LANE_B_BIT])))
      else $error("backplane lane b state wrong");

   chk_rx_pause_hold: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (pause_en_q && rx_pause_s) |=> PORT2_TX_HOLD_OUT)
      else $error("received pause did not hold transmit");

   chk_settings_held_stable: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      $stable({bank1_s, bank2_s}) |=> $stable({an1_q, an2_q, mode_q, lane_a_off_q,
                                                lane_b_off_q, pause_en_q, subord_q}))
      else $error("settings moved without a switch change");

   chk_pause_request_stands: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (PORT2_PAUSE_TX_REQ_OUT && !PAUSE_SENT_IN && pause_en_q) |=> PORT2_PAUSE_TX_REQ_OUT)
      else $error("pause request dropped before sent");

   chk_elected_claims_mastership: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (!subord_q && MASTER_ELECTED_IN) |=> MASTER_CLAIM_OUT)
      else $error("elected module did not claim mastership");

endmodule : psmd_top

//--- tb/psmd_partner.sv
`timescale 1ns/1ps

// ==========================================
// Fiber partner and port two MAC stand-in
// ==========================================
module psmd_partner (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       pause_req_in,
   input  wire logic [3:0] ack_delay_in,
   input  wire logic       send_pause_in,
   output logic            pause_rx_out,
   output logic            pause_sent_out,
   output logic            own_rfd_out
);
   logic [3:0] wait_cnt;
   logic       acked;

   // Partner stays out of remote fault detect mode
   assign own_rfd_out  = 1'b0;
   assign pause_rx_out = send_pause_in;

   // ==========================================
   // Pause frame transmit acknowledge
   // ==========================================
   // One pulse per request; waits for the request to drop before re-arming
   always @(negedge clk_in) begin
      if (!rst_n_in) begin
         wait_cnt       <= 4'h0;
         acked          <= 1'b0;
         pause_sent_out <= 1'b0;
      end else if (pause_req_in && !acked) begin
         pause_sent_out <= (wait_cnt >= ack_delay_in);
         if (wait_cnt >= ack_delay_in) begin
            acked    <= 1'b1;
            wait_cnt <= 4'h0;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end else begin
         pause_sent_out <= 1'b0;
         // A withdrawn request must not leave a part-spent wait behind
         if (!pause_req_in) begin
            acked    <= 1'b0;
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule : psmd_partner

//--- tb/psmd_top_bench.sv
`timescale 1ns/1ps

module psmd_top_bench;
   logic        clk;
   logic        rst_n;
   logic        congested;
   logic        elected;
   logic        send_pause;
   logic [7:0]  b1;
   logic [7:0]  b2;
   logic [3:0]  ack_delay;
   logic        pause_rx;
   logic        pause_sent;
   wire  [17:0] obs;
   logic [17:0] exp_v;
   logic [17:0] expq[$];
   int          err_count;
   int          n_checks;
   int          seed;
   event        note_ev;

   // ==========================================
   // Design and partner
   // ==========================================
   psmd_top dut_u (
      .CLOCK_IN                        (clk),
      .RESET_N_IN                      (rst_n),
      .BANK1_SW_IN                     (b1),
      .BANK2_SW_IN                     (b2),
      .PORT2_PAUSE_RX_IN               (pause_rx),
      .BUFFER_CONGESTED_IN             (congested),
      .PAUSE_SENT_IN                   (pause_sent),
      .MASTER_ELECTED_IN               (elected),
      .PORT1_AUTO_NEGOTIATE_OUT        (obs[17]),
      .PORT2_AUTO_NEGOTIATE_OUT        (obs[16]),
      .PORT1_PAUSE_ADVERTISE_OUT       (obs[15]),
      .PORT2_PAUSE_ADVERTISE_OUT       (obs[14]),
      .PORT1_FULL_DUPLEX_OUT           (obs[13]),
      .PORT2_FULL_DUPLEX_OUT           (obs[12]),
      .LINK_SEGMENT_MODE_OUT           (obs[11]),
      .LINK_PROPAGATE_MODE_OUT         (obs[10]),
      .REMOTE_FAULT_DETECT_MODE_OUT    (obs[9]),
      .SYMMETRIC_FAULT_DETECT_MODE_OUT (obs[8]),
      .BACKPLANE_LANE_A_OFF_OUT        (obs[7]),
      .BACKPLANE_LANE_B_OFF_OUT        (obs[6]),
      .PORT2_PAUSE_ENABLE_OUT          (obs[5]),
      .PORT2_TX_HOLD_OUT               (obs[4]),
      .PORT2_PAUSE_TX_REQ_OUT          (obs[3]),
      .MASTERSHIP_AUTO_SELECT_OUT      (obs[2]),
      .SUBORDINATE_ONLY_MODE_OUT       (obs[1]),
      .MASTER_CLAIM_OUT                (obs[0])
   );

   psmd_partner partner_u (
      .clk_in         (clk),
      .rst_n_in       (rst_n),
      .pause_req_in   (obs[3]),
      .ack_delay_in   (ack_delay),
      .send_pause_in  (send_pause),
      .pause_rx_out   (pause_rx),
      .pause_sent_out (pause_sent),
      .own_rfd_out    ()
   );

   // ==========================================
   // Expected outputs from the switch settings
   // ==========================================
   function automatic logic [17:0] exp_vec(input logic [7:0] s1, input logic [7:0] s2,
                                           input logic rx, input logic el, input logic rq);
      logic [3:0] lm;
      case (s1[7:5])
         3'h0:    lm = 4'h8;
         3'h1:    lm = 4'h4;
         3'h2:    lm = 4'ha;
         3'h3:    lm = 4'h6;
         3'h4:    lm = 4'h1;
         default: lm = 4'h8;
      endcase
      return {~s1[0], ~s1[1], ~s1[0], ~s1[1] & s2[2], 2'h3, lm, ~s2[0], ~s2[1],
              s2[2], s2[2] & rx, rq, ~s2[3], s2[3], ~s2[3] & el};
   endfunction : exp_vec

   task automatic note(input logic rq);
      expq.push_back(exp_vec(b1, b2, pause_rx, elected, rq));
      -> note_ev;
   endtask : note

   // Sampled on the rising edge, where the partner's pulse is settled
   task automatic wait_sent;
      int n;
      n = 0;
      @(posedge clk);
      while (pause_sent !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20) begin
         err_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, pause_sent);
      end
      @(negedge clk);
   endtask : wait_sent

   task automatic conclude;
      if (err_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // ==========================================
   // Clock, monitor, watchdog
   // ==========================================
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial forever begin
      @(note_ev);
      while (expq.size() > 0) begin
         exp_v = expq.pop_front();
         n_checks++;
         if (obs !== exp_v) begin
            err_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp_v, obs);
         end
      end
   end

   initial begin
      repeat (2000) @(posedge clk);
      err_count++;
      conclude();
   end

   // ==========================================
   // Stimulus
   // ==========================================
   initial begin
      rst_n      = 1'b0;
      b1         = 8'h00;
      b2         = 8'h00;
      congested  = 1'b0;
      elected    = 1'b0;
      send_pause = 1'b0;
      ack_delay  = 4'h0;
      seed       = 55870;
      repeat (16) @(negedge clk);
      note(1'b0);
      rst_n = 1'b1;
      // Every link code five times, other switches random
      for (int i = 0; i < 40; i++) begin
         b1         = {i[2:0], 5'($random(seed))};
         b2         = 8'($random(seed));
         send_pause = 1'($random(seed));
         elected    = 1'($random(seed));
         // Hold and claim lag the pause and subordinate switches by four rising edges, one more than the other settings
         repeat (4) @(negedge clk);
         note(1'b0);
      end
      b1         = 8'h00;
      b2         = 8'h04;
      send_pause = 1'b0;
      elected    = 1'b1;
      repeat (3) @(negedge clk);
      // Prompt then slow acknowledge of the pause frame
      for (int k = 0; k < 2; k++) begin
         ack_delay = k ? 4'h6 : 4'h0;
         congested = 1'b1;
         repeat (3) @(negedge clk);
         note(1'b1);
         if (k) begin
            repeat (3) @(negedge clk);
            note(1'b1);
         end
         wait_sent();
         note(1'b0);
         repeat (4) @(negedge clk);
         note(1'b0);
         congested = 1'b0;
         repeat (4) @(negedge clk);
      end
      // Pause switch off: congestion and partner pause both ignored
      b2         = 8'h00;
      repeat (4) @(negedge clk);
      congested  = 1'b1;
      send_pause = 1'b1;
      repeat (5) @(negedge clk);
      note(1'b0);
      congested  = 1'b0;
      repeat (2) @(negedge clk);
      conclude();
   end
endmodule : psmd_top_bench
